//--- hw/pbd_pkg.sv
// Constants, register map and state carrier for the phase build-out control.
// Assumes a 40 MHz clock and byte-wide register accesses on a 7-bit address.
package pbd_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_MHZ       = 40;
    localparam int GAP_NS        = 2500;  // Longest tolerated single gap
    localparam int GAP_CYC       = (GAP_NS * CLK_MHZ) / 1000;
    localparam int HIT_WIN_US    = 1000;  // Window for repeated gaps
    localparam int DETECT_US     = 1000;  // Out-of-range detection time
    localparam int RESTORE_US    = 10000; // Quality good before reuse

    // ----------------------------------------
    // Register offsets and fields
    // ----------------------------------------
    localparam logic [6:0] ADR_HOLD_LO = 7'h41;
    localparam logic [6:0] ADR_HOLD_HI = 7'h42;
    localparam logic [6:0] ADR_PBO_CTL = 7'h48;
    localparam logic [6:0] ADR_FREEZE  = 7'h4f;
    localparam logic [6:0] ADR_BW      = 7'h69;
    localparam logic [6:0] ADR_ADJ_LO  = 7'h70;
    localparam logic [6:0] ADR_ADJ_HI  = 7'h71;
    localparam logic [6:0] ADR_BIAS    = 7'h72;
    localparam logic [6:0] ADR_AUTO    = 7'h76;
    localparam logic [6:0] ADR_STATUS  = 7'h79;
    localparam int BIT_PBO_EN = 2;
    localparam int BIT_AUTO   = 4;
    localparam int BIT_FREEZE = 0;

    // ----------------------------------------
    // Ranges and reset values
    // ----------------------------------------
    localparam logic [3:0] BW_MAX       = 4'h9;    // Ten corner steps
    localparam logic [9:0] HOLD_IN_DEF  = 10'h073; // 9.2 ppm / 0.08 ppm
    localparam logic [9:0] HOLD_IN_MAX  = 10'h3e8; // 80 ppm / 0.08 ppm
    localparam logic signed [7:0] BIAS_LIM = 8'sh0e; // 1.4 ns / 0.101 ns

    // ----------------------------------------
    // Build-out sequencer and state carrier
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } pbd_fsm_e;

    typedef struct packed {
        pbd_fsm_e           st;
        logic [1:0]         sel;
        logic               sel_ok;
        logic [3:0]         unsvc;
        logic               pbo_en;
        logic               auto_pbo;
        logic               freeze;
        logic [3:0]         bw;
        logic [9:0]         hold_in;
        logic [7:0]         adj_lo;
        logic               lo_wr;
        logic signed [15:0] adj;
        logic signed [7:0]  bias;
        logic signed [15:0] acc;
        logic [19:0]        gap;
        logic [1:0]         hits;
        logic [19:0]        win;
        logic [19:0]        oor;
        logic [3:0][19:0]   good;
        logic               evt;
        logic [7:0]         rdata;
    } pbd_state_s;

    localparam pbd_state_s PBD_RST = '{
        st: ST_IDLE, pbo_en: 1'b1, hold_in: HOLD_IN_DEF, default: '0};

endpackage : pbd_pkg

//--- hw/pbd_dpll_ctrl.sv
// Phase build-out control, reference qualification and fine phase adjust.
// Assumes register accesses decoded from the serial port, and a DPLL that
// reports lock, the selected reference's frequency offset and phase.
`timescale 1ns/1ps
`default_nettype none

module pbd_dpll_ctrl
    import pbd_pkg::*;
#(
    parameter int WIN_CYC     = HIT_WIN_US * CLK_MHZ,
    parameter int DETECT_CYC  = DETECT_US * CLK_MHZ,
    parameter int RESTORE_CYC = RESTORE_US * CLK_MHZ
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Register port
    input  wire logic [6:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // Reference monitors
    input  wire logic [3:0]         ref_active,
    input  wire logic [3:0]         ref_jitter_bad,
    input  wire logic signed [10:0] sel_freq_off,
    // DPLL side
    input  wire logic               dpll_locked,
    input  wire logic signed [15:0] phase_meas,
    input  wire logic               phase_meas_valid,
    output logic      [1:0]         sel_ref,
    output logic                    sel_valid,
    output logic      [3:0]         unserviceable,
    output logic                    holdover_active,
    output logic                    pbo_event,
    output logic signed [15:0]      buildout_offset,
    output logic signed [15:0]      fb_phase_shift,
    output logic      [3:0]         bandwidth_step,
    output logic      [9:0]         hold_in_limit
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic wr_to(input logic [6:0] a);
        wr_to = reg_wr && (reg_addr == a);
    endfunction : wr_to

    function automatic logic [1:0] pick(input logic [3:0] ok);
        pick = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (ok[i]) begin
                pick = i[1:0];
            end
        end
    endfunction : pick

    pbd_state_s s_r;
    pbd_state_s s_nxt;
    logic [3:0] ok_w;
    logic       fail_w;
    logic       pbo_live_w;
    logic       en_rise_w;
    logic signed [15:0] comp_w;
    logic [10:0] mag_w;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.evt = 1'b0;
        mag_w = sel_freq_off[10] ? 11'(-sel_freq_off) : sel_freq_off;
        // Register writes
        if (wr_to(ADR_PBO_CTL)) begin
            s_nxt.pbo_en = reg_wdata[BIT_PBO_EN];
        end
        if (wr_to(ADR_AUTO)) begin
            s_nxt.auto_pbo = reg_wdata[BIT_AUTO];
        end
        if (wr_to(ADR_FREEZE)) begin
            s_nxt.freeze = reg_wdata[BIT_FREEZE];
        end
        if (wr_to(ADR_BW)) begin
            s_nxt.bw = (reg_wdata[3:0] > BW_MAX) ? BW_MAX : reg_wdata[3:0];
        end
        if (wr_to(ADR_HOLD_LO)) begin
            s_nxt.hold_in[7:0] = reg_wdata;
        end
        if (wr_to(ADR_HOLD_HI)) begin
            s_nxt.hold_in[9:8] = reg_wdata[1:0];
        end
        if (s_nxt.hold_in > HOLD_IN_MAX) begin
            s_nxt.hold_in = HOLD_IN_MAX;
        end
        // Bias clamped to its symmetric range
        if (wr_to(ADR_BIAS)) begin
            s_nxt.bias = $signed(reg_wdata);
            if ($signed(reg_wdata) > BIAS_LIM) s_nxt.bias = BIAS_LIM;
            if ($signed(reg_wdata) < -BIAS_LIM) s_nxt.bias = -BIAS_LIM;
        end
        // Low byte is only shadowed, so a half update never moves the output
        if (wr_to(ADR_ADJ_LO)) begin
            s_nxt.adj_lo = reg_wdata;
            s_nxt.lo_wr  = 1'b1;
        end
        if (wr_to(ADR_ADJ_HI) && s_r.lo_wr) begin
            s_nxt.adj   = {reg_wdata, s_r.adj_lo};
            s_nxt.lo_wr = 1'b0;
        end
        // Gap tracking on the selected reference
        if (!ref_active[s_r.sel] && s_r.sel_ok) begin
            s_nxt.gap = s_r.gap + 20'd1;
            if (s_r.gap == '0) begin
                s_nxt.hits = s_r.hits + 2'd1;
                s_nxt.win  = 20'(WIN_CYC);
            end
        end else begin
            s_nxt.gap = '0;
        end
        // Expiry must not swallow the hit counted by a gap starting now
        if (s_r.win != '0) begin
            s_nxt.win = s_nxt.win - 20'd1;
        end else if (s_r.gap == '0 && s_nxt.gap == '0) begin
            s_nxt.hits = '0;
        end
        // Hold-in check on the selected reference
        if (mag_w > {1'b0, s_r.hold_in}) begin
            s_nxt.oor = s_r.oor + 20'd1;
        end else begin
            s_nxt.oor = '0;
        end
        // Long gap, second gap in window, off-range or jitter
        fail_w = s_r.sel_ok && ((s_r.gap >= 20'(GAP_CYC))
               || (s_r.hits >= 2'd2)
               || (s_r.oor >= 20'(DETECT_CYC))
               || ref_jitter_bad[s_r.sel]);
        // Recovery qualification per reference
        for (int i = 0; i < 4; i++) begin
            if (ref_active[i] && !ref_jitter_bad[i]) begin
                if (s_r.good[i] != 20'(RESTORE_CYC)) s_nxt.good[i] = s_r.good[i] + 20'd1;
            end else begin
                s_nxt.good[i] = '0;
            end
            if (s_r.good[i] == 20'(RESTORE_CYC)) s_nxt.unsvc[i] = 1'b0;
        end
        ok_w = ~s_nxt.unsvc & ref_active;
        if (fail_w) begin
            s_nxt.unsvc[s_r.sel] = 1'b1;
            ok_w[s_r.sel] = 1'b0;
            s_nxt.gap  = '0;
            s_nxt.hits = '0;
            s_nxt.oor  = '0;
        end
        // Non-revertive: reselect only after failure or when none held
        if (fail_w || !s_r.sel_ok) begin
            s_nxt.sel    = pick(ok_w);
            s_nxt.sel_ok = |ok_w;
        end
        // Build-out events
        pbo_live_w = s_r.pbo_en && !s_r.freeze;
        en_rise_w  = s_nxt.pbo_en && !s_r.pbo_en && dpll_locked && !s_r.freeze;
        if ((fail_w && |ok_w && pbo_live_w) || en_rise_w) begin
            s_nxt.evt = 1'b1;
            s_nxt.st  = ST_HOLD;
        end
        comp_w = s_r.acc - phase_meas + 16'(s_r.bias);
        case (s_r.st)
            ST_IDLE: begin
            end
            ST_HOLD: begin
                if (s_r.freeze || !s_r.pbo_en) begin
                    s_nxt.st = ST_IDLE; // Freeze keeps present offset
                end else if (phase_meas_valid && !s_nxt.evt) begin
                    s_nxt.acc = comp_w;
                    s_nxt.st  = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // Disabled build-out lets the DPLL pull back to zero error
        if (!s_nxt.pbo_en) begin
            s_nxt.acc = '0;
            s_nxt.st  = ST_IDLE;
        end
        // Registered read data
        if (reg_rd) begin
            case (reg_addr)
                ADR_PBO_CTL: s_nxt.rdata = 8'(s_r.pbo_en) << BIT_PBO_EN;
                ADR_AUTO:    s_nxt.rdata = 8'(s_r.auto_pbo) << BIT_AUTO;
                ADR_FREEZE:  s_nxt.rdata = 8'(s_r.freeze) << BIT_FREEZE;
                ADR_BW:      s_nxt.rdata = {4'h0, s_r.bw};
                ADR_HOLD_LO: s_nxt.rdata = s_r.hold_in[7:0];
                ADR_HOLD_HI: s_nxt.rdata = {6'h00, s_r.hold_in[9:8]};
                ADR_ADJ_LO:  s_nxt.rdata = s_r.adj[7:0];
                ADR_ADJ_HI:  s_nxt.rdata = s_r.adj[15:8];
                ADR_BIAS:    s_nxt.rdata = s_r.bias;
                ADR_STATUS:  s_nxt.rdata = {s_r.sel_ok, s_r.st == ST_HOLD,
                                            s_r.sel, s_r.unsvc};
                default:     s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= PBD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata       = s_r.rdata;
    assign sel_ref         = s_r.sel;
    assign sel_valid       = s_r.sel_ok;
    assign unserviceable   = s_r.unsvc;
    assign holdover_active = (s_r.st == ST_HOLD);
    assign pbo_event       = s_r.evt;
    assign buildout_offset = s_r.acc;
    assign bandwidth_step  = s_r.bw;
    assign hold_in_limit   = s_r.hold_in;
    // Feedback shift lets the DPLL slew outputs at its own bandwidth
    assign fb_phase_shift  = (s_r.pbo_en || s_r.auto_pbo) ? 16'sh0000 : s_r.adj;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_event_holdover: assert property (@(posedge clock) disable iff (reset)
        pbo_event |-> holdover_active) else $error("event without holdover");
    a_comp_applied: assert property (@(posedge clock) disable iff (reset)
        holdover_active && phase_meas_valid && s_r.pbo_en && !s_r.freeze && !pbo_event && !fail_w
        |=> buildout_offset == $past(comp_w) && !holdover_active) else $error("bad compensation");
    a_disable_zero: assert property (@(posedge clock) disable iff (reset)
        !s_r.pbo_en |-> buildout_offset == 16'sh0000 && !holdover_active) else $error("offset kept");
    a_frozen_steady: assert property (@(posedge clock) disable iff (reset)
        s_r.freeze && s_r.pbo_en ##1 s_r.pbo_en |-> $stable(buildout_offset) && !pbo_event)
        else $error("frozen offset moved");
    a_fine_gated: assert property (@(posedge clock) disable iff (reset)
        (s_r.pbo_en || s_r.auto_pbo) |-> fb_phase_shift == 16'sh0000) else $error("adjust leaked");
    a_pair_shadow: assert property (@(posedge clock) disable iff (reset)
        reg_wr && reg_addr == ADR_ADJ_LO |=> $stable(s_r.adj)) else $error("half adjust applied");
    a_bw_range: assert property (@(posedge clock) disable iff (reset)
        bandwidth_step <= BW_MAX) else $error("bandwidth out of range");
    a_bias_range: assert property (@(posedge clock) disable iff (reset)
        s_r.bias <= BIAS_LIM && s_r.bias >= -BIAS_LIM) else $error("bias out of range");
    a_fail_drop: assert property (@(posedge clock) disable iff (reset)
        fail_w |=> (unserviceable[$past(s_r.sel)] && sel_ref != $past(s_r.sel)) || !sel_valid)
        else $error("failed reference kept");

endmodule : pbd_dpll_ctrl

`default_nettype wire

//--- test/pbd_ref_model.sv
// Partner model: reference monitors and DPLL phase detector beside the block.
// Assumes the bench drops references by mask and chooses the phase measured.
`timescale 1ns/1ps
`default_nettype none

module pbd_ref_model
    import pbd_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Bench controls
    input  wire logic [3:0]         drop_mask,
    input  wire logic signed [15:0] meas_val,
    // Block side
    input  wire logic               holdover_active,
    output logic      [3:0]         ref_active,
    output logic      [3:0]         ref_jitter_bad,
    output logic signed [10:0]      sel_freq_off,
    output logic                    dpll_locked,
    output logic signed [15:0]      phase_meas,
    output logic                    phase_meas_valid
);
    logic [1:0] dly_r;

    // Lost references stay dead while masked; loop stays locked, on frequency
    // Host runs eight kHz lock mode, so large adjust jumps never unlock the loop
    assign ref_active     = ~drop_mask;
    assign ref_jitter_bad = 4'h0;
    assign sel_freq_off   = 11'sh000;
    assign dpll_locked    = 1'b1;

    // Phase answer a few cycles into holdover; scrambled outside the pulse
    // so a design that samples it late sees meas_val only on alternate cycles
    always_ff @(posedge clock) begin
        if (reset) begin
            dly_r            <= 2'h0;
            phase_meas_valid <= 1'b0;
            phase_meas       <= 16'sh5a5a;
        end else begin
            dly_r            <= holdover_active ? dly_r + 2'h1 : 2'h0;
            phase_meas_valid <= holdover_active && dly_r == 2'h2;
            phase_meas       <= (holdover_active && dly_r == 2'h2) ? meas_val : ~phase_meas;
        end
    end
endmodule : pbd_ref_model

`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the phase build-out control block.
// Assumes the package constants and the reference/DPLL partner model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import pbd_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [3:0] drop_mask = 4'h0, ref_active, ref_jitter_bad, unserviceable;
    logic signed [10:0] sel_freq_off;
    logic signed [15:0] meas_val = 16'sh0000, phase_meas, buildout_offset, fb_phase_shift;
    logic dpll_locked, phase_meas_valid, sel_valid, holdover_active, pbo_event;
    logic [1:0] sel_ref;
    logic [3:0] bandwidth_step;
    logic [9:0] hold_in_limit;
    int n_mismatch = 0, samples_checked = 0;
    bit ok;

    // Clock, 25 ns period
    always #12.5 clock = ~clock;

    pbd_dpll_ctrl #(.WIN_CYC(20), .DETECT_CYC(20), .RESTORE_CYC(30)) pbd_dpll_ctrl_inst (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_active(ref_active),
        .ref_jitter_bad(ref_jitter_bad), .sel_freq_off(sel_freq_off), .dpll_locked(dpll_locked),
        .phase_meas(phase_meas), .phase_meas_valid(phase_meas_valid), .sel_ref(sel_ref),
        .sel_valid(sel_valid), .unserviceable(unserviceable), .holdover_active(holdover_active),
        .pbo_event(pbo_event), .buildout_offset(buildout_offset), .fb_phase_shift(fb_phase_shift),
        .bandwidth_step(bandwidth_step), .hold_in_limit(hold_in_limit));

    pbd_ref_model pbd_ref_model_inst (
        .clock(clock), .reset(reset), .drop_mask(drop_mask), .meas_val(meas_val),
        .holdover_active(holdover_active), .ref_active(ref_active), .ref_jitter_bad(ref_jitter_bad),
        .sel_freq_off(sel_freq_off), .dpll_locked(dpll_locked), .phase_meas(phase_meas),
        .phase_meas_valid(phase_meas_valid));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One write; strobe drops at the edge that takes it
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask : rd

    // Bounded wait: kind 0 for a build-out pulse, 1 for holdover ending
    task automatic wait_for(input int kind, input int n, output bit seen);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            seen = kind == 0 ? pbo_event === 1'b1 : holdover_active === 1'b0;
            if (!seen) begin
                @(posedge clock);
                #1;
            end
        end
    endtask : wait_for

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [7:0] d;
        chk(sel_valid, 1'b1);
        chk(sel_ref, 2'h0);
        chk(unserviceable, 4'h0);
        chk(buildout_offset, 16'h0000);
        chk(fb_phase_shift, 16'h0000);
        chk(bandwidth_step, 4'h0);
        chk(hold_in_limit, HOLD_IN_DEF);
        rd(7'h00, d);
        chk(d, 8'h00);
        rd(ADR_STATUS, d);
        chk(d, 8'h80);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs;
        logic [7:0] d;
        wr(ADR_BW, 8'h05);
        chk(bandwidth_step, 4'h5);
        wr(ADR_BW, 8'h0f);
        chk(bandwidth_step, BW_MAX);
        rd(ADR_BW, d);
        chk(d, 8'h09);
        rd(ADR_PBO_CTL, d);
        chk(d, 8'h04);
        wr(ADR_HOLD_LO, 8'h20);
        wr(ADR_HOLD_HI, 8'h01);
        chk(hold_in_limit, 10'h120);
        wr(ADR_HOLD_LO, 8'hff);
        wr(ADR_HOLD_HI, 8'h03);
        chk(hold_in_limit, HOLD_IN_MAX);
        wr(ADR_HOLD_LO, 8'h73);
        wr(ADR_HOLD_HI, 8'h00);
        $display("test registers done");
    endtask : t_regs

    // Loss of the selected reference: switch, holdover, measure, offset
    task automatic t_switch;
        wr(ADR_BIAS, 8'h03);
        meas_val  = 16'sd20;
        drop_mask <= 4'h1;
        wait_for(0, 150, ok);
        chk(ok, 1'b1);
        chk(sel_ref, 2'h1);
        chk(holdover_active, 1'b1);
        chk(unserviceable[0], 1'b1);
        wait_for(1, 12, ok);
        chk(ok, 1'b1);
        chk(buildout_offset, 16'hffef);
        repeat (50) @(posedge clock);
        #1;
        chk(buildout_offset, 16'hffef);
        $display("test switch done");
    endtask : t_switch

    // Frozen: later switch raises no event and keeps the offset
    task automatic t_freeze;
        wr(ADR_FREEZE, 8'h01);
        drop_mask <= 4'h3;
        wait_for(0, 150, ok);
        chk(ok, 1'b0);
        chk(sel_ref, 2'h2);
        chk(buildout_offset, 16'hffef);
        wr(ADR_FREEZE, 8'h00);
        $display("test freeze done");
    endtask : t_freeze

    // Disable clears offset; fine adjust pairs and gating
    task automatic t_adjust;
        wr(ADR_PBO_CTL, 8'h00);
        chk(buildout_offset, 16'h0000);
        wr(ADR_ADJ_HI, 8'h55);
        chk(fb_phase_shift, 16'h0000);
        wr(ADR_ADJ_LO, 8'h34);
        chk(fb_phase_shift, 16'h0000);
        wr(ADR_ADJ_HI, 8'h92);
        chk(fb_phase_shift, 16'h9234);
        wr(ADR_AUTO, 8'h10);
        chk(fb_phase_shift, 16'h0000);
        wr(ADR_AUTO, 8'h00);
        chk(fb_phase_shift, 16'h9234);
        $display("test adjust done");
    endtask : t_adjust

    // Enabling while locked fires an event; bias clamps at its limit
    task automatic t_enable;
        wr(ADR_BIAS, 8'h7f);
        meas_val = 16'sd0;
        wr(ADR_PBO_CTL, 8'h04);
        wait_for(0, 3, ok);
        chk(ok, 1'b1);
        chk(fb_phase_shift, 16'h0000);
        wait_for(1, 12, ok);
        chk(ok, 1'b1);
        chk(buildout_offset, 16'h000e);
        $display("test enable done");
    endtask : t_enable

    // Two short gaps inside the window: the first is tolerated, the second reselects
    task automatic t_hits;
        drop_mask <= 4'h7;
        repeat (3) @(posedge clock);
        drop_mask <= 4'h3;
        repeat (3) @(posedge clock);
        #1;
        chk(sel_ref, 2'h2);
        drop_mask <= 4'h7;
        wait_for(0, 10, ok);
        chk(ok, 1'b1);
        chk(sel_ref, 2'h3);
        chk(unserviceable, 4'h7);
        wait_for(1, 12, ok);
        chk(ok, 1'b1);
        chk(buildout_offset, 16'h001c);
        $display("test hits done");
    endtask : t_hits

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        t_reset();
        t_regs();
        t_switch();
        t_freeze();
        t_adjust();
        t_enable();
        t_hits();
        wrap_up();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
